// ==== src/fesr_params.svh ====
`ifndef FESR_PARAMS_SVH
`define FESR_PARAMS_SVH

// Byte addresses of the registers on the APB.
`define FESR_OFF_CONTROL 32'h0018_0000
`define FESR_OFF_STATUS 32'h0018_0004
`define FESR_OFF_CYCLE 32'h0018_0008
`define FESR_OFF_DAC_START 32'h0018_000C
`define FESR_OFF_DAC_END 32'h0018_0010
`define FESR_OFF_DAC_STEP 32'h0018_0014
`define FESR_OFF_SAT_STEP 32'h0018_0018

// Reset values of the writable registers.
`define FESR_RST_CONTROL 30'h0000_0000
`define FESR_RST_CYCLE 24'h00_0000
`define FESR_RST_DAC_START 14'h0FF0
`define FESR_RST_DAC_END 14'h0000
`define FESR_RST_DAC_STEP 18'h0_0000
`define FESR_RST_SAT_STEP 14'h0000

// Field widths and positions.
`define FESR_DAC_W 14
`define FESR_FRAC_W 10
`define FESR_CTRL_W 30
`define FESR_STAT_W 12
`define FESR_CYCLE_W 24
`define FESR_STEP_W 18
`define FESR_CTRL_FW_START_POS 1

`endif

// ==== src/fesr_pkg.sv ====
package fesr_pkg;

    // Ramp control word, bit 29 down to bit 0.
    typedef struct packed {
        logic [13:0] rectifier_ramp_initial;
        logic [2:0] reserved;
        logic saturation_step_enable;
        logic ramp_done_irq_enable;
        logic delay_done_irq_enable;
        logic prebias_done_irq_enable;
        logic pcm_start_select;
        logic rectifier_ramp_enable;
        logic [1:0] master_select;
        logic slave_done_sync_enable;
        logic slave_delay_sync_enable;
        logic control_line_enable;
        logic firmware_start;
        logic ramp_enable;
    } fesr_ctrl_type;

    // Ramp status word, bit 11 down to bit 0.
    typedef struct packed {
        logic conversion_done_raw;
        logic ramp_done_latched;
        logic delay_done_latched;
        logic prebias_done_latched;
        logic converter_clipped_high;
        logic converter_clipped_low;
        logic end_of_conversion;
        logic prebias_in_progress;
        logic ramp_in_progress;
        logic ramp_done_raw;
        logic delay_done_raw;
        logic prebias_done_raw;
    } fesr_stat_type;

    // Ramp cycle timing word, bit 23 down to bit 0.
    typedef struct packed {
        logic [15:0] delay_cycles;
        logic reserved;
        logic [6:0] cycles_per_step;
    } fesr_cycle_type;

    // Error converter and pre-bias indications from the analog side.
    typedef struct packed {
        logic conversion_done_raw;
        logic end_of_conversion;
        logic converter_clipped_high;
        logic converter_clipped_low;
        logic prebias_in_progress;
        logic prebias_done;
    } fesr_fe_type;

    typedef enum logic [1:0] {
        FESR_IDLE = 2'b00,
        FESR_DELAY = 2'b01,
        FESR_RAMP = 2'b11
    } fesr_state_type;

endpackage

// ==== src/fesr_ramp.sv ====
// Summary of operation
// - Hold a 14-bit rectifier ramp starting value in oscillator periods.
// - While saturated, step by saturation step if enabled, else by normal step.
// - Ramp-complete interrupt only while its enable bit is set; default off.
// - Delay-complete interrupt only while its enable bit is set; default off.
// - Pre-bias-complete interrupt only while its enable bit is set; default off.
// - Peak current mode starts from DAC value or filter output per select bit.
// - Rectifier ramp operates only while its enable bit is set.
// - Slave mode takes master pulses from channel 0, 1 or 2.
// - Slave-complete sync starts the ramp on master ramp-complete pulse.
// - Slave-delay sync starts the ramp on master delay-complete pulse.
// - Control line starts a ramp only while its enable bit is set.
// - Firmware start bit starts a ramp and is cleared by hardware.
// - Ramp runs under hardware only while ramp enable is set.
// - Latched ramp, delay and pre-bias completion flags are readable.
// - Raw ramp, delay and pre-bias completion flags are readable.
// - Report converter saturation at high and at low limit.
// - Busy flags for ramp in progress and pre-bias in progress.
// - Report raw conversion done and end of conversion.
// - Wait delay count steps, each cycles per step plus one; zero starts at once.
// - Each step lasts programmed value plus one switching cycles.
// - Ramp the DAC toward the 14-bit ending value.
// - Step is 18 bits: 8 whole counts and 10 fraction bits.
// - Saturation step gives counts to adjust; zero means no adjustment.
`include "fesr_params.svh"

module fesr_ramp (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic switch_cycle_tick,
    input wire logic control_line,
    input wire logic [2:0] master_delay_done,
    input wire logic [2:0] master_ramp_done,
    input wire logic peak_current_mode,
    input wire logic [13:0] filter_output,
    input wire fesr_pkg::fesr_fe_type front_end,
    output logic [13:0] dac_out,
    output logic ramp_irq,
    output logic delay_done_pulse,
    output logic ramp_done_pulse,
    output logic rectifier_ramp_run,
    output logic [13:0] rectifier_start_value
);

    localparam int ACC_W = `FESR_DAC_W + `FESR_FRAC_W;

    fesr_pkg::fesr_ctrl_type ctrl_reg;
    fesr_pkg::fesr_cycle_type cycle_reg;
    logic [13:0] dac_start_reg;
    logic [13:0] dac_end_reg;
    logic [17:0] dac_step_reg;
    logic [13:0] sat_step_reg;
    fesr_pkg::fesr_state_type state_reg;
    logic [6:0] step_cnt_reg;
    logic [15:0] delay_cnt_reg;
    logic [ACC_W-1:0] acc_reg;
    logic ramp_done_raw_reg;
    logic delay_done_raw_reg;
    logic ramp_done_lat_reg;
    logic delay_done_lat_reg;
    logic prebias_done_lat_reg;
    logic prebias_prev_reg;
    logic setup;
    logic wr_en;
    logic rd_status;
    logic start;
    logic step_evt;
    logic delay_end;
    logic saturated;
    logic [ACC_W-1:0] end_full;
    logic [ACC_W-1:0] inc;
    logic [ACC_W:0] acc_up;
    logic [ACC_W:0] end_plus;
    logic ramp_up;
    logic ramp_reached;
    logic [ACC_W-1:0] acc_next;
    fesr_pkg::fesr_stat_type status;

    // Picks the pulse of the master channel; select value 3 picks none.
    function automatic logic fesr_pick(input logic [2:0] pulses, input logic [1:0] sel);
        fesr_pick = (sel == 2'h3) ? 1'b0 : pulses[sel];
    endfunction

    // Bus phase decode.
    assign setup = psel && !penable;
    assign wr_en = psel && penable && pready && pwrite; // A write lands at the edge that completes the access.
    assign rd_status = setup && !pwrite && (paddr == `FESR_OFF_STATUS);

    // Start sources, all gated by the ramp enable.
    assign start = (state_reg == fesr_pkg::FESR_IDLE) && ctrl_reg.ramp_enable &&
        (ctrl_reg.firmware_start ||
         (ctrl_reg.control_line_enable && control_line) ||
         (ctrl_reg.slave_done_sync_enable && fesr_pick(master_ramp_done, ctrl_reg.master_select)) ||
         (ctrl_reg.slave_delay_sync_enable && fesr_pick(master_delay_done, ctrl_reg.master_select)));

    // A step ends after cycles per step plus one switching cycles.
    assign step_evt = switch_cycle_tick && (step_cnt_reg == cycle_reg.cycles_per_step);
    assign delay_end = step_evt && (delay_cnt_reg + 16'h0001 >= cycle_reg.delay_cycles);

    // Step size and the reach test of the accumulator.
    assign saturated = front_end.converter_clipped_high || front_end.converter_clipped_low;
    assign end_full = {dac_end_reg, {`FESR_FRAC_W{1'b0}}};
    assign inc = (saturated && ctrl_reg.saturation_step_enable) ?
        {sat_step_reg, {`FESR_FRAC_W{1'b0}}} :
        {6'h00, dac_step_reg};
    assign ramp_up = end_full > acc_reg;
    assign acc_up = {1'b0, acc_reg} + {1'b0, inc};
    assign end_plus = {1'b0, end_full} + {1'b0, inc};
    assign ramp_reached = ramp_up ? (acc_up >= {1'b0, end_full}) : ({1'b0, acc_reg} <= end_plus);
    assign acc_next = ramp_reached ? end_full : (ramp_up ? acc_up[ACC_W-1:0] : acc_reg - inc);

    // Status word as software reads it.
    always_comb begin
        status.conversion_done_raw = front_end.conversion_done_raw;
        status.ramp_done_latched = ramp_done_lat_reg;
        status.delay_done_latched = delay_done_lat_reg;
        status.prebias_done_latched = prebias_done_lat_reg;
        status.converter_clipped_high = front_end.converter_clipped_high;
        status.converter_clipped_low = front_end.converter_clipped_low;
        status.end_of_conversion = front_end.end_of_conversion;
        status.prebias_in_progress = front_end.prebias_in_progress;
        status.ramp_in_progress = (state_reg != fesr_pkg::FESR_IDLE);
        status.ramp_done_raw = ramp_done_raw_reg;
        status.delay_done_raw = delay_done_raw_reg;
        status.prebias_done_raw = front_end.prebias_done;
    end

    // APB answer: one access cycle, registered read data, error on unmapped address.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= setup;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
            if (setup) begin
                case (paddr)
                    `FESR_OFF_CONTROL: prdata <= {2'h0, ctrl_reg};
                    `FESR_OFF_STATUS: prdata <= {20'h0_0000, status};
                    `FESR_OFF_CYCLE: prdata <= {8'h00, cycle_reg};
                    `FESR_OFF_DAC_START: prdata <= {18'h0_0000, dac_start_reg};
                    `FESR_OFF_DAC_END: prdata <= {18'h0_0000, dac_end_reg};
                    `FESR_OFF_DAC_STEP: prdata <= {14'h0000, dac_step_reg};
                    `FESR_OFF_SAT_STEP: prdata <= {18'h0_0000, sat_step_reg};
                    default: pslverr <= 1'b1;
                endcase
            end
        end
    end

    // Control register; the start bit is cleared once the ramp logic has seen it.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= `FESR_RST_CONTROL;
        end else begin
            if ((state_reg != fesr_pkg::FESR_IDLE) || (start && ctrl_reg.firmware_start)) begin
                ctrl_reg.firmware_start <= 1'b0;
            end
            if (wr_en && (paddr == `FESR_OFF_CONTROL)) begin
                ctrl_reg <= pwdata[`FESR_CTRL_W-1:0];
                ctrl_reg.reserved <= 3'h0;
            end
        end
    end

    // Timing and DAC registers.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cycle_reg <= `FESR_RST_CYCLE;
            dac_start_reg <= `FESR_RST_DAC_START;
            dac_end_reg <= `FESR_RST_DAC_END;
            dac_step_reg <= `FESR_RST_DAC_STEP;
            sat_step_reg <= `FESR_RST_SAT_STEP;
        end else if (wr_en) begin
            case (paddr)
                `FESR_OFF_CYCLE: cycle_reg <= {pwdata[23:8], 1'b0, pwdata[6:0]};
                `FESR_OFF_DAC_START: dac_start_reg <= pwdata[13:0];
                `FESR_OFF_DAC_END: dac_end_reg <= pwdata[13:0];
                `FESR_OFF_DAC_STEP: dac_step_reg <= pwdata[`FESR_STEP_W-1:0];
                `FESR_OFF_SAT_STEP: sat_step_reg <= pwdata[13:0];
                default: cycle_reg <= cycle_reg;
            endcase
        end
    end

    // Sequencer: idle, delay, ramp; disabling the ramp aborts to idle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= fesr_pkg::FESR_IDLE;
        end else if (!ctrl_reg.ramp_enable) begin
            state_reg <= fesr_pkg::FESR_IDLE;
        end else begin
            case (state_reg)
                fesr_pkg::FESR_IDLE: begin
                    if (start) begin
                        state_reg <= (cycle_reg.delay_cycles == 16'h0000) ?
                            fesr_pkg::FESR_RAMP : fesr_pkg::FESR_DELAY;
                    end
                end
                fesr_pkg::FESR_DELAY: begin
                    if (delay_end) begin
                        state_reg <= fesr_pkg::FESR_RAMP;
                    end
                end
                fesr_pkg::FESR_RAMP: begin
                    if (step_evt && ramp_reached) begin
                        state_reg <= fesr_pkg::FESR_IDLE;
                    end
                end
                default: state_reg <= fesr_pkg::FESR_IDLE;
            endcase
        end
    end

    // Switching-cycle and delay counters.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            step_cnt_reg <= 7'h00;
            delay_cnt_reg <= 16'h0000;
        end else if (state_reg == fesr_pkg::FESR_IDLE) begin
            step_cnt_reg <= 7'h00;
            delay_cnt_reg <= 16'h0000;
        end else if (switch_cycle_tick) begin
            step_cnt_reg <= step_evt ? 7'h00 : step_cnt_reg + 7'h01;
            if (step_evt && (state_reg == fesr_pkg::FESR_DELAY)) begin
                delay_cnt_reg <= delay_cnt_reg + 16'h0001;
            end
        end
    end

    // DAC accumulator, loaded at start and stepped once per step.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_reg <= {ACC_W{1'b0}};
        end else if (start) begin
            acc_reg <= {(peak_current_mode && ctrl_reg.pcm_start_select) ? filter_output : dac_start_reg,
                {`FESR_FRAC_W{1'b0}}};
        end else if ((state_reg == fesr_pkg::FESR_RAMP) && step_evt) begin
            acc_reg <= acc_next;
        end
    end

    // Raw completion flags, cleared by the next start; pulses for slave channels.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ramp_done_raw_reg <= 1'b0;
            delay_done_raw_reg <= 1'b0;
            delay_done_pulse <= 1'b0;
            ramp_done_pulse <= 1'b0;
        end else begin
            delay_done_pulse <= ctrl_reg.ramp_enable && ((start && cycle_reg.delay_cycles == 16'h0000) ||
                (state_reg == fesr_pkg::FESR_DELAY && delay_end));
            ramp_done_pulse <= ctrl_reg.ramp_enable && state_reg == fesr_pkg::FESR_RAMP && step_evt && ramp_reached;
            if (start) begin
                ramp_done_raw_reg <= 1'b0;
                delay_done_raw_reg <= 1'b0;
            end else begin
                ramp_done_raw_reg <= ramp_done_raw_reg || ramp_done_pulse;
                delay_done_raw_reg <= delay_done_raw_reg || delay_done_pulse;
            end
        end
    end

    // Latched flags clear on a status read; a new event in that cycle wins.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ramp_done_lat_reg <= 1'b0;
            delay_done_lat_reg <= 1'b0;
            prebias_done_lat_reg <= 1'b0;
            prebias_prev_reg <= 1'b0;
        end else begin
            prebias_prev_reg <= front_end.prebias_done;
            ramp_done_lat_reg <= ramp_done_pulse || (ramp_done_lat_reg && !rd_status);
            delay_done_lat_reg <= delay_done_pulse || (delay_done_lat_reg && !rd_status);
            prebias_done_lat_reg <= (front_end.prebias_done && !prebias_prev_reg) ||
                (prebias_done_lat_reg && !rd_status);
        end
    end

    // Outputs toward the DAC, the rectifier timing and the interrupt line.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dac_out <= 14'h0000;
            ramp_irq <= 1'b0;
            rectifier_ramp_run <= 1'b0;
            rectifier_start_value <= 14'h0000;
        end else begin
            dac_out <= acc_reg[ACC_W-1:`FESR_FRAC_W];
            ramp_irq <= (ramp_done_lat_reg && ctrl_reg.ramp_done_irq_enable) ||
                (delay_done_lat_reg && ctrl_reg.delay_done_irq_enable) ||
                (prebias_done_lat_reg && ctrl_reg.prebias_done_irq_enable);
            rectifier_ramp_run <= ctrl_reg.rectifier_ramp_enable && (state_reg == fesr_pkg::FESR_RAMP);
            rectifier_start_value <= ctrl_reg.rectifier_ramp_initial;
        end
    end

    // Checks on the sequencer, flags and interrupt.
    property p_fw_clear;
        @(posedge pclk) disable iff (!presetn)
        (start && ctrl_reg.firmware_start && !wr_en) |=> !ctrl_reg.firmware_start;
    endproperty
    a_fw_clear: assert property (p_fw_clear) else $error("Firmware start not cleared.");

    property p_irq_cause;
        @(posedge pclk) disable iff (!presetn)
        ramp_irq |-> $past((ramp_done_lat_reg && ctrl_reg.ramp_done_irq_enable) ||
            (delay_done_lat_reg && ctrl_reg.delay_done_irq_enable) ||
            (prebias_done_lat_reg && ctrl_reg.prebias_done_irq_enable));
    endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("Interrupt without enabled flag.");

    property p_ramp_irq;
        @(posedge pclk) disable iff (!presetn)
        (ramp_done_lat_reg && ctrl_reg.ramp_done_irq_enable) |=> ramp_irq;
    endproperty
    a_ramp_irq: assert property (p_ramp_irq) else $error("Ramp done interrupt missing.");

    property p_delay_irq;
        @(posedge pclk) disable iff (!presetn)
        (delay_done_lat_reg && ctrl_reg.delay_done_irq_enable) |=> ramp_irq;
    endproperty
    a_delay_irq: assert property (p_delay_irq) else $error("Delay done interrupt missing.");

    property p_disabled_idle;
        @(posedge pclk) disable iff (!presetn)
        !ctrl_reg.ramp_enable |=> (state_reg == fesr_pkg::FESR_IDLE);
    endproperty
    a_disabled_idle: assert property (p_disabled_idle) else $error("Ramp ran while disabled.");

    property p_control_start;
        @(posedge pclk) disable iff (!presetn)
        ((state_reg == fesr_pkg::FESR_IDLE) && ctrl_reg.ramp_enable && ctrl_reg.control_line_enable &&
            control_line) |=> (state_reg != fesr_pkg::FESR_IDLE) || !ctrl_reg.ramp_enable;
    endproperty
    a_control_start: assert property (p_control_start) else $error("Control line did not start ramp.");

    property p_zero_delay;
        @(posedge pclk) disable iff (!presetn)
        (start && cycle_reg.delay_cycles == 16'h0000) |=> (state_reg == fesr_pkg::FESR_RAMP) ##0 delay_done_pulse;
    endproperty
    a_zero_delay: assert property (p_zero_delay) else $error("Zero delay did not ramp at once.");

    property p_delay_to_ramp;
        @(posedge pclk) disable iff (!presetn)
        (state_reg == fesr_pkg::FESR_DELAY && delay_end && ctrl_reg.ramp_enable) |=> delay_done_pulse ##1 delay_done_raw_reg;
    endproperty
    a_delay_to_ramp: assert property (p_delay_to_ramp) else $error("Delay done not flagged.");

    property p_step_len;
        @(posedge pclk) disable iff (!presetn)
        ((state_reg != fesr_pkg::FESR_IDLE) && ctrl_reg.ramp_enable && switch_cycle_tick && !step_evt) |=>
            (step_cnt_reg == $past(step_cnt_reg) + 7'h01);
    endproperty
    a_step_len: assert property (p_step_len) else $error("Step length wrong.");

    property p_busy;
        @(posedge pclk) disable iff (!presetn)
        ramp_done_pulse |-> (state_reg == fesr_pkg::FESR_IDLE) ##1 (dac_out == $past(dac_end_reg));
    endproperty
    a_busy: assert property (p_busy) else $error("Ramp did not end at the end value.");

    property p_rect;
        @(posedge pclk) disable iff (!presetn)
        rectifier_ramp_run |-> $past(ctrl_reg.rectifier_ramp_enable);
    endproperty
    a_rect: assert property (p_rect) else $error("Rectifier ramp ran while disabled.");

    c_full_ramp: cover property (@(posedge pclk) disable iff (!presetn) ramp_done_pulse);
    c_delay: cover property (@(posedge pclk) disable iff (!presetn)
        state_reg == fesr_pkg::FESR_DELAY ##1 state_reg == fesr_pkg::FESR_RAMP);
    c_irq: cover property (@(posedge pclk) disable iff (!presetn) $rose(ramp_irq));

endmodule // fesr_ramp

// ==== tb/fesr_fe_model.sv ====
// Behavioural error converter and power stage seen from the ramp block.
module fesr_fe_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [5:0] fe_cmd,
    output logic switch_cycle_tick,
    output fesr_pkg::fesr_fe_type front_end
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] div_reg;

    // One switching cycle every four bus clocks, marked by a one-cycle tick.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_reg <= 2'h0;
            switch_cycle_tick <= 1'b0;
        end else begin
            div_reg <= div_reg + 2'h1;
            switch_cycle_tick <= (div_reg == 2'h3);
        end
    end

    // Converter and pre-bias indications follow the commanded levels a cycle later.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            front_end <= '0;
        end else begin
            front_end <= fesr_pkg::fesr_fe_type'(fe_cmd);
        end
    end
endmodule // fesr_fe_model

// ==== tb/tb_top.sv ====
`include "fesr_params.svh"

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err, tick, control_line = 1'b0, ramp_irq, dly_p, done_p, rect_run;
    logic [2:0] m_dly = 3'h0, m_done = 3'h0;
    logic [5:0] fe_cmd = 6'h0;
    logic pcm = 1'b0;
    logic [13:0] filt = 14'h0000;
    logic [13:0] dac_out, rect_start;
    fesr_pkg::fesr_fe_type front_end;
    int n_mismatch = 0, n_compared = 0, cyc = 0;
    logic [31:0] ctl [5] = '{32'h5, 32'h9, 32'h29, 32'h49, 32'h31};
    logic [3:0] trg [5] = '{4'h8, 4'h1, 4'h2, 4'h4, 4'h2};

    fesr_ramp i_fesr_ramp (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .switch_cycle_tick(tick), .control_line(control_line), .master_delay_done(m_dly),
        .master_ramp_done(m_done), .peak_current_mode(pcm), .filter_output(filt),
        .front_end(front_end), .dac_out(dac_out), .ramp_irq(ramp_irq), .delay_done_pulse(dly_p),
        .ramp_done_pulse(done_p), .rectifier_ramp_run(rect_run), .rectifier_start_value(rect_start));
    fesr_fe_model i_fesr_fe_model (.pclk(pclk), .presetn(presetn), .fe_cmd(fe_cmd),
        .switch_cycle_tick(tick), .front_end(front_end));

    // Bus clock at 100 MHz.
    always #5 pclk = ~pclk;

    // Cuts a hung run short.
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            wrap_up();
        end
    end

    task automatic wrap_up();
        if (n_mismatch == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // One bus transfer: setup, then access held until ready is sampled high.
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk); // Idle cycle, so the next setup never reassigns psel in the same step.
    endtask

    // Drives one cycle of start pulses: bit 3 is the control line, bits 2:0 the master channels.
    task automatic pulse(input logic [3:0] t, input logic on_done);
        control_line <= t[3];
        m_dly <= on_done ? 3'h0 : t[2:0];
        m_done <= on_done ? t[2:0] : 3'h0;
        @(posedge pclk);
        control_line <= 1'b0;
        m_dly <= 3'h0;
        m_done <= 3'h0;
        @(posedge pclk);
    endtask

    // Waits for the end of a ramp and checks the final DAC value.
    task automatic wait_done();
        for (int k = 0; k < 300 && done_p !== 1'b1; k++) @(posedge pclk);
        chk({31'h0, done_p}, 32'h1);
        repeat (2) @(posedge pclk);
        chk({18'h0, dac_out}, 32'h5);
    endtask

    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, `FESR_OFF_CONTROL, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, `FESR_OFF_DAC_START, 32'h0);
        chk(rd, 32'h0FF0);
        apb(1'b0, 32'h0018_001C, 32'h0);
        chk({31'h0, err}, 32'h1);
        // Short ramp from 2 up to 5, one whole count a step, one step of delay.
        apb(1'b1, `FESR_OFF_DAC_START, 32'h2);
        apb(1'b1, `FESR_OFF_DAC_END, 32'h5);
        apb(1'b1, `FESR_OFF_DAC_STEP, 32'h400);
        apb(1'b1, `FESR_OFF_CYCLE, 32'h180);
        apb(1'b0, `FESR_OFF_CYCLE, 32'h0);
        chk(rd, 32'h100);
        fe_cmd <= 6'h28;
        apb(1'b1, `FESR_OFF_CONTROL, 32'h1234_0803);
        wait_done();
        chk({31'h0, ramp_irq}, 32'h1);
        chk({18'h0, rect_start}, 32'h1234);
        apb(1'b0, `FESR_OFF_CONTROL, 32'h0);
        chk(rd, 32'h1234_0801);
        apb(1'b0, `FESR_OFF_STATUS, 32'h0);
        chk(rd, 32'hE86);
        @(posedge pclk);
        chk({31'h0, ramp_irq}, 32'h0);
        apb(1'b0, `FESR_OFF_STATUS, 32'h0);
        chk(rd, 32'h886);
        // Control line and slave sync starts: wrong sources first must not start, then the chosen one must.
        for (int i = 0; i < 5; i++) begin
            apb(1'b1, `FESR_OFF_CONTROL, ctl[i]);
            pulse({1'b0, ~trg[i][2:0]}, i == 4);
            repeat (8) @(posedge pclk);
            apb(1'b0, `FESR_OFF_STATUS, 32'h0);
            chk({31'h0, rd[3]}, 32'h0);
            pulse(trg[i], i == 4);
            wait_done();
        end
        // Down ramp from the filter output in saturated steps of two, with delay and pre-bias interrupts.
        apb(1'b0, `FESR_OFF_STATUS, 32'h0);
        chk(rd, 32'hE86);
        apb(1'b1, `FESR_OFF_SAT_STEP, 32'h2);
        pcm <= 1'b1;
        filt <= 14'h0009;
        apb(1'b1, `FESR_OFF_CONTROL, 32'h1783);
        for (int k = 0; k < 100 && dly_p !== 1'b1; k++) @(posedge pclk);
        chk({31'h0, dly_p}, 32'h1);
        repeat (5) @(posedge pclk);
        chk({18'h0, dac_out}, 32'h7);
        chk({31'h0, rect_run}, 32'h1);
        chk({31'h0, ramp_irq}, 32'h1);
        wait_done();
        apb(1'b0, `FESR_OFF_STATUS, 32'h0);
        chk(rd, 32'hE86);
        fe_cmd <= 6'h29;
        repeat (4) @(posedge pclk);
        chk({31'h0, ramp_irq}, 32'h1);
        apb(1'b0, `FESR_OFF_STATUS, 32'h0);
        chk(rd, 32'h987);
        wrap_up();
    end
endmodule // tb_top
